//--- rtl/sdo_upload_params.svh
`ifndef SDO_UPLOAD_PARAMS_SVH
`define SDO_UPLOAD_PARAMS_SVH

// ****************************************************************
// command specifiers, byte 0 bits 7..5
// ****************************************************************
`define CCS_INIT_UPLOAD   3'h2
`define SCS_INIT_UPLOAD   3'h2
`define CCS_SEG_UPLOAD    3'h3
`define SCS_SEG_UPLOAD    3'h0

// ****************************************************************
// payload limits in bytes
// ****************************************************************
`define EXPEDITED_MAX     5'h04
`define SEGMENT_MAX       5'h07
`define OBJECT_MAX        5'h10

// ****************************************************************
// register byte addresses
// ****************************************************************
`define CTRL_OFS          12'h000
`define STATUS_OFS        12'h004
`define KEY_BASE_OFS      12'h010
`define DATA_BASE_OFS     12'h040

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CTRL_ENABLE_BIT   0
`define CTRL_SIZE_BIT     1
`define CTRL_RESET        32'h0000_0003
`define KEY_INDEX_LSB     0
`define KEY_SUB_LSB       16
`define KEY_LEN_LSB       24

`endif

//--- rtl/sdo_upload_pkg.sv
package sdo_upload_pkg;

    // apb request from the bus master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    // apb answer from this slave
    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_type;

    // one 8-byte data frame, byte k in payload[k]
    typedef struct packed {
        logic            valid;
        logic [7:0][7:0] payload;
    } frame_type;

    typedef enum logic {
        idle_st,
        segment_st
    } server_state_type;

endpackage

//--- rtl/sdo_upload_server.sv
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "sdo_upload_params.svh"
// Operation
// - initiate response carries command code 2 and echoes index, sub-index
// - objects of four bytes or fewer go out expedited in one response
// - transfer bit 0 means segmented exchange follows, 1 means expedited
// - unused-byte count only valid with expedited and size bits, else 0
// - size bit is 1 when the size is stated, 0 otherwise
// - multiplexer holds index in bytes 1-2 and sub-index in byte 3
// - normal transfer with size puts total byte count in bytes 4-7
// - expedited with size carries four minus unused-count value bytes
// - normal without size leaves data reserved; expedited carries value
// - all unused and reserved bits are sent as zero
// - segment response carries command code 0
// - segment response copies the toggle bit of its request
// - continuation flag 0 while more segments remain, 1 on the last
// - at most seven object bytes per segment response
// - segment unused-byte count names trailing empty bytes
// - multi-byte values travel least significant byte first

module sdo_upload_server
    import sdo_upload_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire apb_req_type apb_in,
    output apb_rsp_type      apb_out,
    input  wire frame_type   rx_in,
    output logic             rx_ready,
    output frame_type        tx_out,
    input  wire logic        tx_ready
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [31:0]      ctrl_q;
    logic [31:0]      key_q [4];
    logic [31:0]      mem_q [16];
    logic [7:0]       reject_q;
    server_state_type state_q;
    logic [1:0]       slot_q;
    logic [4:0]       len_q;
    logic [4:0]       off_q;
    logic             tog_q;
    frame_type        tx_q;
    logic [7:0][7:0]  frame_d;

    // one object byte from the store, words packed low byte first
    function automatic logic [7:0] get_byte(input logic [3:0] pos,
                                            input logic [31:0] w0,
                                            input logic [31:0] w1,
                                            input logic [31:0] w2,
                                            input logic [31:0] w3);
        logic [31:0] word;
        word = w0;
        unique case (pos[3:2])
            2'h0: word = w0;
            2'h1: word = w1;
            2'h2: word = w2;
            2'h3: word = w3;
        endcase
        get_byte = word[8*pos[1:0] +: 8];
    endfunction

    // ****************************************************************
    // request decode
    // ****************************************************************
    wire [7:0]  rx_head   = rx_in.payload[0];
    wire [2:0]  rx_cmd    = rx_head[7:5];
    wire        rx_tog    = rx_head[4];
    wire [15:0] rq_index  = {rx_in.payload[2], rx_in.payload[1]};
    wire [7:0]  rq_sub    = rx_in.payload[3];
    wire        enabled   = ctrl_q[`CTRL_ENABLE_BIT];
    wire        size_on   = ctrl_q[`CTRL_SIZE_BIT];
    wire        take      = rx_in.valid && rx_ready;

    // object lookup over the four slots, first match wins
    logic       hit;
    logic [1:0] hit_slot;
    always_comb begin
        hit = 1'b0;
        hit_slot = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (key_q[i][`KEY_INDEX_LSB +: 16] == rq_index &&
                key_q[i][`KEY_SUB_LSB +: 8] == rq_sub &&
                key_q[i][`KEY_LEN_LSB +: 5] != 5'h00 &&
                key_q[i][`KEY_LEN_LSB +: 5] <= `OBJECT_MAX) begin
                hit = 1'b1;
                hit_slot = 2'(i);
            end
        end
    end

    wire [4:0] obj_len   = key_q[hit_slot][`KEY_LEN_LSB +: 5];
    wire       init_ok   = take && enabled && hit &&
                           rx_cmd == `CCS_INIT_UPLOAD;
    wire       expedited = obj_len <= `EXPEDITED_MAX;
    // a toggle mismatch or a stray request gets no answer at all
    wire       seg_ok    = take && enabled && state_q == segment_st &&
                           rx_cmd == `CCS_SEG_UPLOAD &&
                           rx_tog == tog_q;
    wire       ignored   = take && !init_ok && !seg_ok;

    // segment sizing from what is left of the object
    wire [4:0] remain    = len_q - off_q;
    wire       seg_last  = remain <= `SEGMENT_MAX;
    wire [4:0] seg_cnt   = seg_last ? remain : `SEGMENT_MAX;
    wire [4:0] seg_gap   = `SEGMENT_MAX - seg_cnt;
    wire [4:0] exp_gap   = `EXPEDITED_MAX - obj_len;

    // slot words for the two readers of the store
    wire [1:0] rd_slot   = init_ok ? hit_slot : slot_q;
    wire [31:0] w0 = mem_q[{rd_slot, 2'h0}];
    wire [31:0] w1 = mem_q[{rd_slot, 2'h1}];
    wire [31:0] w2 = mem_q[{rd_slot, 2'h2}];
    wire [31:0] w3 = mem_q[{rd_slot, 2'h3}];

    // ****************************************************************
    // response frame assembly
    // ****************************************************************
    // start from zero so every unused or reserved bit leaves as 0
    always_comb begin
        frame_d = '0;
        if (init_ok) begin
            frame_d[0][7:5] = `SCS_INIT_UPLOAD;
            frame_d[0][1] = expedited;
            frame_d[0][0] = size_on;
            frame_d[1] = rx_in.payload[1];
            frame_d[2] = rx_in.payload[2];
            frame_d[3] = rx_in.payload[3];
            if (expedited) begin
                if (size_on) begin
                    frame_d[0][3:2] = exp_gap[1:0];
                end
                for (int k = 0; k < 4; k++) begin
                    if (5'(k) < obj_len) begin
                        frame_d[4 + k] = get_byte(4'(k),
                                                  w0, w1, w2, w3);
                    end
                end
            end else if (size_on) begin
                frame_d[4] = {3'h0, obj_len};
            end
        end else if (seg_ok) begin
            frame_d[0][7:5] = `SCS_SEG_UPLOAD;
            frame_d[0][4] = rx_tog;
            frame_d[0][3:1] = seg_gap[2:0];
            frame_d[0][0] = seg_last;
            for (int k = 0; k < 7; k++) begin
                if (5'(k) < seg_cnt) begin
                    frame_d[1 + k] = get_byte(4'(off_q + 5'(k)),
                                              w0, w1, w2, w3);
                end
            end
        end
    end

    // ****************************************************************
    // transfer sequencing
    // ****************************************************************
    // a normal transfer arms the segment phase, a new initiate restarts
    always_ff @(posedge clock) begin
        if (reset || !enabled) begin
            state_q <= idle_st;
            slot_q <= 2'h0;
            len_q <= 5'h00;
            off_q <= 5'h00;
            tog_q <= 1'b0;
        end else if (init_ok) begin
            state_q <= expedited ? idle_st : segment_st;
            slot_q <= hit_slot;
            len_q <= obj_len;
            off_q <= 5'h00;
            tog_q <= 1'b0;
        end else if (seg_ok) begin
            off_q <= off_q + seg_cnt;
            tog_q <= ~tog_q;
            if (seg_last) begin
                state_q <= idle_st;
            end
        end
    end

    // one frame held until taken; no new request while it waits
    always_ff @(posedge clock) begin
        if (reset) begin
            tx_q <= '0;
        end else if (init_ok || seg_ok) begin
            tx_q <= {1'b1, frame_d};
        end else if (tx_ready) begin
            tx_q.valid <= 1'b0;
        end
    end

    assign rx_ready = !tx_q.valid;
    assign tx_out   = tx_q;

    // ****************************************************************
    // apb slave
    // ****************************************************************
    wire        access   = apb_in.psel && apb_in.penable;
    wire [11:0] addr     = apb_in.paddr;
    wire        sel_ctrl = addr == `CTRL_OFS;
    wire        sel_stat = addr == `STATUS_OFS;
    wire        sel_key  = addr[11:4] == 8'(`KEY_BASE_OFS >> 4) &&
                           addr[1:0] == 2'h0;
    wire        sel_mem  = addr[11:6] == 6'(`DATA_BASE_OFS >> 6) &&
                           addr[1:0] == 2'h0;
    wire        mapped   = sel_ctrl || sel_stat || sel_key || sel_mem;
    wire        wr_en    = access && apb_in.pwrite;
    wire [31:0] status   = {8'h00, reject_q, 3'h0, remain,
                            6'h00, tog_q, state_q == segment_st};

    // register writes, zero wait states
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_q <= `CTRL_RESET;
            for (int i = 0; i < 4; i++) begin
                key_q[i] <= 32'h0000_0000;
            end
        end else if (wr_en && sel_ctrl) begin
            ctrl_q <= {30'h0, apb_in.pwdata[1:0]};
        end else if (wr_en && sel_key) begin
            key_q[addr[3:2]] <= {3'h0, apb_in.pwdata[28:0]};
        end
    end

    // object store needs no reset; empty slots have length zero
    always_ff @(posedge clock) begin
        if (wr_en && sel_mem) begin
            mem_q[addr[5:2]] <= apb_in.pwdata;
        end
    end

    // count of ignored requests, saturating, cleared by writing status
    always_ff @(posedge clock) begin
        if (reset) begin
            reject_q <= 8'h00;
        end else if (ignored && reject_q != 8'hFF) begin
            reject_q <= reject_q + 8'h01;
        end else if (wr_en && sel_stat) begin
            reject_q <= 8'h00;
        end
    end

    // read mux; unmapped reads answer zero with an error
    wire [31:0] rd_data = sel_ctrl ? ctrl_q :
                          sel_stat ? status :
                          sel_key  ? key_q[addr[3:2]] :
                          sel_mem  ? mem_q[addr[5:2]] : 32'h0000_0000;

    assign apb_out.pready  = 1'b1;
    assign apb_out.prdata  = rd_data;
    assign apb_out.pslverr = access && !mapped;

endmodule // sdo_upload_server

//--- verification/sdo_upload_server_chk.sv
`timescale 1ns/100ps
module sdo_upload_server_chk
    import sdo_upload_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset,
    input wire apb_req_type apb_in,
    input wire apb_rsp_type apb_out,
    input wire frame_type   rx_in,
    input wire logic        rx_ready,
    input wire frame_type   tx_out,
    input wire logic        tx_ready
);
    // ****
    // answer frame fields
    // ****
    wire logic       take = rx_in.valid && rx_ready;
    wire logic [7:0] cmd  = tx_out.payload[0];
    wire logic       init = tx_out.valid && cmd[7:5] == 3'h2;
    wire logic       seg  = tx_out.valid && cmd[7:5] == 3'h0;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    init_echo_a: assert property (
        (take && rx_in.payload[0][7:5] == 3'h2) ##1 tx_out.valid
        |-> init && tx_out.payload[3:1] == $past(rx_in.payload[3:1]))
        else $error("bad initiate answer");
    seg_toggle_a: assert property (
        (take && rx_in.payload[0][7:5] == 3'h3) ##1 tx_out.valid
        |-> seg && cmd[4] == $past(rx_in.payload[0][4]))
        else $error("bad segment answer");
    answer_time_a: assert property (
        $rose(tx_out.valid) |-> $past(take))
        else $error("answer without request");
    answer_hold_a: assert property (
        tx_out.valid && !tx_ready |=> tx_out.valid && $stable(tx_out.payload))
        else $error("answer dropped early");
    init_count_a: assert property (
        init && !(cmd[1] && cmd[0]) |-> cmd[3:2] == 2'h0)
        else $error("stray unused count");
    init_spare_a: assert property (
        init |-> !cmd[4])
        else $error("spare bit set");
    norm_size_a: assert property (
        init && cmd[1:0] == 2'b01
        |-> tx_out.payload[4] > 8'h04 && tx_out.payload[7:5] == '0)
        else $error("bad size word");
    seg_full_a: assert property (
        seg && !cmd[0] |-> cmd[3:1] == 3'h0)
        else $error("short inner segment");
    seg_tail_a: assert property (
        seg && cmd[3:1] == 3'h6 |-> tx_out.payload[7:2] == '0)
        else $error("dirty segment tail");
endmodule // sdo_upload_server_chk

bind sdo_upload_server sdo_upload_server_chk chk_i (.clock(clock),
    .reset(reset), .apb_in(apb_in), .apb_out(apb_out), .rx_in(rx_in),
    .rx_ready(rx_ready), .tx_out(tx_out), .tx_ready(tx_ready));

//--- verification/sdo_client_model.sv
`timescale 1ns/100ps
module sdo_client_model
    import sdo_upload_pkg::*;
(
    input  wire logic      clock,
    input  wire frame_type tx_out,
    input  wire logic      rx_ready,
    output frame_type      rx_in,
    output logic           tx_ready
);
    int stall = 0;

    initial begin
        rx_in = '0;
        tx_ready = 1'b0;
    end

    // one request out, bit 64 of rsp says an answer came back
    task automatic xfer(input logic [63:0] req, output logic [64:0] rsp);
        rsp = '0;
        rx_in <= {1'b1, req};
        do @(posedge clock); while (rx_ready !== 1'b1);
        // released line shows inverted bytes so stale data cannot pass
        rx_in <= {1'b0, ~req};
        repeat (stall) @(posedge clock);
        for (int n = 0; n < 8 && tx_out.valid !== 1'b1; n++)
            @(posedge clock);
        if (tx_out.valid === 1'b1) begin
            tx_ready <= 1'b1;
            @(posedge clock);
            rsp = {1'b1, tx_out.payload};
            tx_ready <= 1'b0;
        end
    endtask
endmodule // sdo_client_model

//--- verification/tb.sv
`timescale 1ns/100ps
module tb
    import sdo_upload_pkg::*;
;
    logic        clock;
    logic        reset;
    apb_req_type apb_in;
    apb_rsp_type apb_out;
    frame_type   rx_in;
    frame_type   tx_out;
    logic        rx_ready;
    logic        tx_ready;
    logic [31:0] seed = 32'hB69F;
    logic [31:0] r;
    logic        e;
    logic [64:0] rsp;
    logic [7:0]  obj [16];
    int          lens [10] = '{1, 2, 3, 4, 5, 7, 8, 9, 14, 16};
    int          mismatches = 0;
    int          check_count = 0;
    int          ign = 0;
    int          cycles = 0;

    sdo_upload_server DUT (.clock(clock), .reset(reset), .apb_in(apb_in),
        .apb_out(apb_out), .rx_in(rx_in), .rx_ready(rx_ready),
        .tx_out(tx_out), .tx_ready(tx_ready));
    sdo_client_model cli (.clock(clock), .tx_out(tx_out),
        .rx_ready(rx_ready), .rx_in(rx_in), .tx_ready(tx_ready));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [64:0] got, input logic [64:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one apb transfer; zero wait states, but pready is still waited for
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        apb_in <= {1'b1, 1'b0, w, a, d};
        @(posedge clock);
        apb_in.penable <= 1'b1;
        do @(posedge clock); while (apb_out.pready !== 1'b1);
        r = apb_out.prdata;
        e = apb_out.pslverr;
        apb_in <= '0;
        @(posedge clock);
    endtask

    function automatic logic [63:0] init_exp(int len, bit sz,
                                             logic [15:0] ix, logic [7:0] sb);
        logic [63:0] f;
        f = {32'h0, sb, ix, 8'h0};
        if (len <= 4) begin
            f[7:0] = sz ? 8'(8'h43 | (4 - len) << 2) : 8'h42;
            for (int k = 0; k < len; k++) f[32+8*k +: 8] = obj[k];
        end else begin
            f[7:0] = sz ? 8'h41 : 8'h40;
            if (sz) f[63:32] = len;
        end
        return f;
    endfunction

    function automatic logic [63:0] seg_exp(int off, int len);
        logic [63:0] f;
        int c;
        f = '0;
        c = (len - off > 7) ? 7 : len - off;
        f[7:0] = 8'((off / 7 % 2) << 4 | (7 - c) << 1 | (off + c == len));
        for (int k = 0; k < c; k++) f[8+8*k +: 8] = obj[off + k];
        return f;
    endfunction

    // one whole upload of slot 0, with a wrongly toggled request slipped in when the object exceeds seven bytes
    task automatic upload(int len, bit sz);
        logic [15:0] ix;
        logic [7:0]  sb;
        ix = 16'(rnd());
        sb = 8'(rnd());
        apb(1'b1, 12'h010, {3'h0, 5'(len), sb, ix});
        cli.stall = int'(rnd() % 3);
        cli.xfer({32'h0, sb, ix, 8'h40}, rsp);
        chk(rsp, {1'b1, init_exp(len, sz, ix, sb)});
        // a normal transfer must leave the segment phase armed at toggle 0
        if (len > 4) begin
            apb(1'b0, 12'h004, 32'h0);
            chk({e, r[12:0]}, {1'b0, 5'(len), 8'h01});
        end
        for (int off = 0; len > 4 && off < len; off += 7) begin
            cli.xfer({56'h0, 3'h3, 1'(off / 7 % 2), 4'h0}, rsp);
            chk(rsp, {1'b1, seg_exp(off, len)});
            if (off == 0 && len > 7) begin
                cli.xfer({56'h0, 8'h60}, rsp);
                chk(rsp[64], 1'b0);
                ign++;
            end
        end
    endtask

    // hang guard: the whole run needs a few hundred cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    // main sequence
    initial begin
        reset = 1'b1;
        apb_in = '0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        apb(1'b0, 12'h000, 32'h0);
        chk({e, r}, {1'b0, 32'h3});
        apb(1'b0, 12'h008, 32'h0);
        chk({e, r}, {1'b1, 32'h0});
        for (int k = 0; k < 16; k++) obj[k] = 8'(rnd());
        for (int w = 0; w < 4; w++)
            apb(1'b1, 12'(64 + 4 * w),
                {obj[4*w+3], obj[4*w+2], obj[4*w+1], obj[4*w]});
        cli.xfer({56'h0, 8'h60}, rsp);
        chk(rsp[64], 1'b0);
        ign++;
        for (int sz = 1; sz >= 0; sz--) begin
            apb(1'b1, 12'h000, {30'h0, sz[0], 1'b1});
            foreach (lens[i]) upload(lens[i], sz[0]);
        end
        // disabled server and unknown object both stay silent
        apb(1'b1, 12'h010, 32'h0100_0000);
        apb(1'b1, 12'h000, 32'h0);
        cli.xfer({56'h0, 8'h40}, rsp);
        chk(rsp[64], 1'b0);
        ign++;
        apb(1'b1, 12'h000, 32'h3);
        cli.xfer({48'h0, 8'h01, 8'h40}, rsp);
        chk(rsp[64], 1'b0);
        ign++;
        cli.xfer({56'h0, 8'h40}, rsp);
        chk(rsp, {1'b1, init_exp(1, 1'b1, 16'h0, 8'h0)});
        apb(1'b0, 12'h004, 32'h0);
        chk(r[23:16], ign);
        finish_test();
    end
endmodule // tb
